// [hw/nvh_ctrl.sv]
`timescale 1ns/100ps
// Function
// - host holds address steady through write
// - host keeps output gate high writing
// - host never writing as power recall ends
// - six ordered reads trigger software store
// - sequence steps are select-timed reads
// - steps are reads, gate level free
// - recall uses same five, own sixth
module nvh_ctrl
    import nvh_pkg::*;
#(
    parameter int unsigned STORE_CYCLES   = nvh_pkg::STORE_CYC,
    parameter int unsigned RESTORE_CYCLES = nvh_pkg::RESTORE_CYC
) (
    // clock and reset
    input  wire logic                        clock_in,
    input  wire logic                        rst_in,
    // command port
    input  wire logic                        cmd_valid_in,
    input  wire nvh_pkg::nvh_op_t            cmd_op_in,
    input  wire logic [nvh_pkg::ADDR_W-1:0]  cmd_addr_in,
    input  wire logic [nvh_pkg::DATA_W-1:0]  cmd_wdata_in,
    output logic                             cmd_ready_out,
    output logic                             rsp_valid_out,
    output logic [nvh_pkg::DATA_W-1:0]       rsp_rdata_out,
    // supply monitor pin
    input  wire logic                        supply_ok_in,
    // memory pins
    output logic                             chip_sel_n_out,
    output logic                             out_gate_n_out,
    output logic                             write_n_out,
    output logic [nvh_pkg::ADDR_W-1:0]       address_inputs_out,
    input  wire logic [nvh_pkg::DATA_W-1:0]  data_pins_in,
    output logic [nvh_pkg::DATA_W-1:0]       data_pins_out,
    output logic                             data_pins_oe_n_out
);

    import nvh_pkg::*;

    typedef enum logic [2:0] {
        ST_POWER,
        ST_IDLE,
        ST_SETUP,
        ST_STROBE,
        ST_RECOVER,
        ST_BUSY
    } nvh_state_t;

    nvh_state_t            state_reg;
    nvh_op_t               op_reg;
    logic [DATA_W-1:0]     wdata_reg;
    logic [2:0]            seq_idx_reg;
    logic                  tmr_load_reg;
    logic [TMR_W-1:0]      tmr_value_reg;
    logic                  tmr_done;
    logic [2:0]            supply_sync_reg;
    logic                  supply_ok_reg;
    logic [DATA_W-1:0]     dq_s1_reg;
    logic [DATA_W-1:0]     dq_s2_reg;
    logic [DATA_W-1:0]     dq_s3_reg;
    logic [DATA_W-1:0]     dq_val_reg;
    logic                  is_seq;
    logic                  tmr_ready;

    // sequence address for a step, top address bit left at zero
    function automatic logic [SEQ_W-1:0] seq_addr(
        input logic [2:0] idx,
        input logic       recall
    );
        logic [SEQ_W-1:0] a;
        a = SEQ_ADDR_1;
        unique case (idx)
            3'h0: a = SEQ_ADDR_1;
            3'h1: a = SEQ_ADDR_2;
            3'h2: a = SEQ_ADDR_3;
            3'h3: a = SEQ_ADDR_4;
            3'h4: a = SEQ_ADDR_5;
            default: a = recall ? SEQ_ADDR_RECALL : SEQ_ADDR_STORE;
        endcase
        return a;
    endfunction

    assign is_seq    = (op_reg == NVH_OP_STORE) || (op_reg == NVH_OP_RECALL);
    assign tmr_ready = tmr_done && !tmr_load_reg;

    // shared wait counter for strobes and busy intervals
    nvh_timer #(
        .WIDTH (TMR_W)
    ) u_timer (
        .clock_in (clock_in),
        .rst_in   (rst_in),
        .load_in  (tmr_load_reg),
        .value_in (tmr_value_reg),
        .done_out (tmr_done)
    );

    // supply pin synchroniser, level taken when stages two and three agree
    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            supply_sync_reg <= 3'h0;
            supply_ok_reg   <= 1'b0;
        end else begin
            supply_sync_reg <= {supply_sync_reg[1:0], supply_ok_in};
            if (supply_sync_reg[1] == supply_sync_reg[2]) begin
                supply_ok_reg <= supply_sync_reg[2];
            end
        end
    end

    // read data pipeline from the data pins
    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            dq_s1_reg <= '0;
            dq_s2_reg <= '0;
            dq_s3_reg  <= '0;
            dq_val_reg <= '0;
        end else begin
            dq_s1_reg <= data_pins_in;
            dq_s2_reg <= dq_s1_reg;
            dq_s3_reg <= dq_s2_reg;
            // a byte counts once stages two and three agree
            if (dq_s2_reg == dq_s3_reg) begin
                dq_val_reg <= dq_s3_reg;
            end
        end
    end

    // main access sequencer
    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            state_reg          <= ST_POWER;
            op_reg             <= NVH_OP_READ;
            wdata_reg          <= '0;
            seq_idx_reg        <= SEQ_FIRST;
            tmr_load_reg       <= 1'b1;
            tmr_value_reg      <= TMR_W'(RESTORE_CYCLES);
            cmd_ready_out      <= 1'b0;
            rsp_valid_out      <= 1'b0;
            rsp_rdata_out      <= '0;
            chip_sel_n_out     <= 1'b1;
            out_gate_n_out     <= 1'b1;
            write_n_out        <= 1'b1;
            address_inputs_out <= '0;
            data_pins_out      <= '0;
            data_pins_oe_n_out <= 1'b1;
        end else begin
            tmr_load_reg  <= 1'b0;
            rsp_valid_out <= 1'b0;
            unique case (state_reg)
                // strobes idle high while the power-up recall runs
                ST_POWER: begin
                    chip_sel_n_out <= 1'b1;
                    write_n_out    <= 1'b1;
                    if (!supply_ok_reg) begin
                        tmr_load_reg  <= 1'b1;
                        tmr_value_reg <= TMR_W'(RESTORE_CYCLES);
                    end else if (tmr_ready) begin
                        state_reg     <= ST_IDLE;
                        cmd_ready_out <= 1'b1;
                    end
                end
                ST_IDLE: begin
                    if (!supply_ok_reg) begin
                        state_reg     <= ST_POWER;
                        cmd_ready_out <= 1'b0;
                        tmr_load_reg  <= 1'b1;
                        tmr_value_reg <= TMR_W'(RESTORE_CYCLES);
                    end else if (cmd_valid_in) begin
                        state_reg     <= ST_SETUP;
                        cmd_ready_out <= 1'b0;
                        op_reg        <= cmd_op_in;
                        wdata_reg     <= cmd_wdata_in;
                        seq_idx_reg   <= SEQ_FIRST;
                        // address settles a cycle ahead of the strobes
                        if (cmd_op_in == NVH_OP_STORE ||
                            cmd_op_in == NVH_OP_RECALL) begin
                            address_inputs_out <= {1'b0,
                                seq_addr(SEQ_FIRST, 1'b0)};
                        end else begin
                            address_inputs_out <= cmd_addr_in;
                        end
                    end
                end
                // address already steady, drive data and drop the strobes
                ST_SETUP: begin
                    if (op_reg == NVH_OP_WRITE) begin
                        data_pins_out      <= wdata_reg;
                        data_pins_oe_n_out <= 1'b0;
                        write_n_out        <= 1'b0;
                        out_gate_n_out     <= 1'b1;
                    end else begin
                        write_n_out    <= 1'b1;
                        out_gate_n_out <= 1'b0;
                    end
                    chip_sel_n_out <= 1'b0;
                    tmr_load_reg   <= 1'b1;
                    tmr_value_reg  <= TMR_W'(STROBE_CYC);
                    state_reg      <= ST_STROBE;
                end
                // select held low, cycle closed by select rising
                ST_STROBE: begin
                    if (tmr_ready) begin
                        chip_sel_n_out <= 1'b1;
                        write_n_out    <= 1'b1;
                        out_gate_n_out <= 1'b1;
                        rsp_rdata_out  <= dq_val_reg;
                        state_reg      <= ST_RECOVER;
                    end
                end
                // data held one cycle past the strobe, next step address set
                ST_RECOVER: begin
                    data_pins_oe_n_out <= 1'b1;
                    if (is_seq && seq_idx_reg != SEQ_LAST) begin
                        seq_idx_reg        <= seq_idx_reg + 3'h1;
                        address_inputs_out <= {1'b0,
                            seq_addr(seq_idx_reg + 3'h1,
                                     op_reg == NVH_OP_RECALL)};
                        state_reg          <= ST_SETUP;
                    end else if (is_seq) begin
                        tmr_load_reg <= 1'b1;
                        if (op_reg == NVH_OP_RECALL) begin
                            tmr_value_reg <= TMR_W'(RECALL_CYC);
                        end else begin
                            tmr_value_reg <= TMR_W'(STORE_CYCLES);
                        end
                        state_reg <= ST_BUSY;
                    end else begin
                        rsp_valid_out <= 1'b1;
                        cmd_ready_out <= 1'b1;
                        state_reg     <= ST_IDLE;
                    end
                end
                // no access while the nonvolatile cycle runs
                ST_BUSY: begin
                    if (tmr_ready) begin
                        rsp_valid_out <= 1'b1;
                        cmd_ready_out <= 1'b1;
                        state_reg     <= ST_IDLE;
                    end
                end
                default: begin
                    state_reg <= ST_POWER;
                end
            endcase
        end
    end

endmodule

// [hw/nvh_pkg.sv]
package nvh_pkg;

    // pin widths
    localparam int ADDR_W = 15;
    localparam int SEQ_W  = 14;
    localparam int DATA_W = 8;

    // host command codes
    typedef enum logic [1:0] {
        NVH_OP_READ,
        NVH_OP_WRITE,
        NVH_OP_STORE,
        NVH_OP_RECALL
    } nvh_op_t;

    // software sequence addresses, lower fourteen bits only
    localparam logic [13:0] SEQ_ADDR_1      = 14'h0e38;
    localparam logic [13:0] SEQ_ADDR_2      = 14'h31c7;
    localparam logic [13:0] SEQ_ADDR_3      = 14'h03e0;
    localparam logic [13:0] SEQ_ADDR_4      = 14'h3c1f;
    localparam logic [13:0] SEQ_ADDR_5      = 14'h303f;
    localparam logic [13:0] SEQ_ADDR_STORE  = 14'h0fc0;
    localparam logic [13:0] SEQ_ADDR_RECALL = 14'h0c63;
    localparam logic [2:0]  SEQ_LAST        = 3'h5;
    localparam logic [2:0]  SEQ_FIRST       = 3'h0;

    // clock and device timing
    localparam int CLK_PERIOD_NS  = 10;
    localparam int T_ACCESS_NS    = 45;
    localparam int T_RECALL_US    = 20;
    localparam int T_STORE_MS     = 10;
    localparam int T_RESTORE_US   = 550;
    localparam int SYNC_STAGES    = 3;

    // least times rounded up to whole cycles, the strobe count adding the sync stages
    localparam int STROBE_CYC  = (T_ACCESS_NS + CLK_PERIOD_NS - 1)
                                 / CLK_PERIOD_NS + SYNC_STAGES;
    localparam int RECALL_CYC  = (T_RECALL_US * 1000 + CLK_PERIOD_NS - 1)
                                 / CLK_PERIOD_NS;
    localparam int STORE_CYC   = (T_STORE_MS * 1000000 + CLK_PERIOD_NS - 1)
                                 / CLK_PERIOD_NS;
    localparam int RESTORE_CYC = (T_RESTORE_US * 1000 + CLK_PERIOD_NS - 1)
                                 / CLK_PERIOD_NS;

    localparam int TMR_W = 24;

endpackage

// [hw/nvh_timer.sv]
`timescale 1ns/100ps
module nvh_timer #(
    parameter int WIDTH = 24
) (
    // clock and reset
    input  wire logic             clock_in,
    input  wire logic             rst_in,
    // control
    input  wire logic             load_in,
    input  wire logic [WIDTH-1:0] value_in,
    // status
    output logic                  done_out
);

    logic [WIDTH-1:0] count_reg;

    // load a count and run it down to zero
    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            count_reg <= '0;
        end else if (load_in) begin
            count_reg <= value_in;
        end else if (count_reg != '0) begin
            count_reg <= count_reg - 1'b1;
        end
    end

    // a count of one or less means the wait is over
    assign done_out = (count_reg <= {{(WIDTH-1){1'b0}}, 1'b1});

endmodule

// [dv/nvh_ctrl_chk.sv]
`timescale 1ns/100ps
module nvh_ctrl_chk
    import nvh_pkg::*;
#(
    parameter int unsigned STORE_CYCLES   = 50,
    parameter int unsigned RESTORE_CYCLES = 40
) (
    // clock and reset
    input wire logic                       clock_in,
    input wire logic                       rst_in,
    // command port
    input wire logic                       cmd_valid_in,
    input wire nvh_pkg::nvh_op_t           cmd_op_in,
    input wire logic                       cmd_ready_out,
    input wire logic                       rsp_valid_out,
    input wire logic                       supply_ok_in,
    // memory pins
    input wire logic                       chip_sel_n_out,
    input wire logic                       out_gate_n_out,
    input wire logic                       write_n_out,
    input wire logic [nvh_pkg::ADDR_W-1:0] address_inputs_out,
    input wire logic                       data_pins_oe_n_out
);
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (rst_in);
    // a command is taken on this edge
    wire take = cmd_valid_in && cmd_ready_out;
    wire wr = !chip_sel_n_out && !write_n_out;
    addr_hold_a: assert property (wr && $past(wr) |->
        $stable(address_inputs_out)) else $error("address moved in write");
    addr_chg_a: assert property ($changed(address_inputs_out) |->
        chip_sel_n_out && $past(chip_sel_n_out))
        else $error("address moved while selected");
    gate_wr_a: assert property (!write_n_out |-> out_gate_n_out)
        else $error("output gate low during write");
    rd_free_a: assert property (!out_gate_n_out |->
        write_n_out && data_pins_oe_n_out) else $error("read with contention");
    wr_data_a: assert property (!write_n_out || $rose(write_n_out) |->
        !data_pins_oe_n_out) else $error("write data not driven");
    rd_lat_a: assert property (take && cmd_op_in == NVH_OP_READ |->
        ##[11:12] rsp_valid_out) else $error("read answer late");
    seq_first_a: assert property (take && cmd_op_in[1] |-> ##[1:3]
        (!chip_sel_n_out && address_inputs_out == {1'b0, SEQ_ADDR_1}))
        else $error("sequence start wrong");
    seq_rd_a: assert property (take && cmd_op_in[1] |=>
        write_n_out[*8]) else $error("sequence step wrote");
    pwr_wr_a: assert property ($rose(supply_ok_in) |->
        write_n_out[*8]) else $error("write as supply returned");
    sup_low_a: assert property (!supply_ok_in[*6] |-> !cmd_ready_out)
        else $error("ready with supply low");
    // main scenarios
    cover property (take && cmd_op_in == NVH_OP_WRITE);
    cover property (take && cmd_op_in == NVH_OP_STORE);
    cover property (take && cmd_op_in == NVH_OP_RECALL);
endmodule

bind nvh_ctrl nvh_ctrl_chk #(
    .STORE_CYCLES(STORE_CYCLES),
    .RESTORE_CYCLES(RESTORE_CYCLES)
) u_chk (.clock_in, .rst_in, .cmd_valid_in, .cmd_op_in, .cmd_ready_out,
    .rsp_valid_out, .supply_ok_in, .chip_sel_n_out, .out_gate_n_out,
    .write_n_out, .address_inputs_out, .data_pins_oe_n_out);

// [dv/nvh_dev.sv]
`timescale 1ns/100ps
module nvh_dev
    import nvh_pkg::*;
#(
    parameter int BUSY_NS = 200
) (
    // strobes and pins
    input  wire logic        sel_n_in,
    input  wire logic        gate_n_in,
    input  wire logic        we_n_in,
    input  wire logic [14:0] addr_in,
    input  wire logic [7:0]  data_in,
    input  wire logic        supply_in,
    output logic [7:0]       data_out,
    // operation counts
    output int               n_store_out = 0,
    output int               n_recall_out = 0
);
    logic [7:0]  mem [32768];
    logic [7:0]  nv [32768];
    logic [7:0]  last = 8'h00;
    logic        busy = 1'b0, dirty = 1'b0, wr_on = 1'b0, rd_pend = 1'b0;
    logic [2:0]  step = 3'h0;
    logic [13:0] tab [5] = '{SEQ_ADDR_1, SEQ_ADDR_2, SEQ_ADDR_3,
                             SEQ_ADDR_4, SEQ_ADDR_5};
    wire         wr_end = sel_n_in | we_n_in;
    wire         rd = !sel_n_in && !gate_n_in && we_n_in && !busy;
    wire [13:0]  a14 = addr_in[13:0];
    // released lines show the inverse of the last byte
    assign data_out = rd ? mem[addr_in] : ~last;
    // copy modes: 0 to nonvolatile, 1 to sram, 2 clear sram
    task automatic copy(input int mode);
        for (int i = 0; i < 32768; i++)
            if (mode == 0) nv[i] = mem[i];
            else if (mode == 1) mem[i] = nv[i];
            else mem[i] = 8'h00;
        if (mode < 2) dirty = 1'b0;
    endtask
    task automatic go_busy;
        busy = 1'b1;
        busy <= #BUSY_NS 1'b0;
        step = 3'h0;
    endtask
    initial copy(2);
    always @(negedge wr_end) wr_on = 1'b1;
    always @(negedge sel_n_in) rd_pend = 1'b1;
    // write closes on the first strobe to rise; reads step the detector
    always @(posedge wr_end or posedge sel_n_in) begin
        if (wr_on) begin
            if (!busy && supply_in) begin
                mem[addr_in] = data_in;
                dirty = 1'b1;
            end
            {wr_on, rd_pend, step} = '0;
        end else if (rd_pend && !busy) begin
            rd_pend = 1'b0;
            last = mem[addr_in];
            if (step == 3'h5 && a14 == SEQ_ADDR_STORE
                && supply_in) begin
                copy(0);
                n_store_out++;
                go_busy;
            end else if (step == 3'h5
                         && a14 == SEQ_ADDR_RECALL) begin
                copy(2);
                copy(1);
                n_recall_out++;
                go_busy;
            end else if (step < 3'h5 && a14 == tab[step]) step++;
            else step = {2'b00, a14 == SEQ_ADDR_1};
        end
    end
    // supply loss stores only when dirty; return recalls
    always @(negedge supply_in) begin
        if (dirty) begin
            copy(0);
            n_store_out++;
        end
        copy(2);
    end
    always @(posedge supply_in)
        if ($time > 0) copy(1);
endmodule

// [dv/tb.sv]
`timescale 1ns/100ps
module tb;
    import nvh_pkg::*;
    logic        clock_in = 1'b0, rst_in = 1'b1, supply_ok_in = 1'b1;
    logic        cmd_valid_in = 1'b0;
    nvh_op_t     cmd_op_in = NVH_OP_READ;
    logic [14:0] cmd_addr_in = 15'h0000;
    logic [7:0]  cmd_wdata_in = 8'h00, rd;
    wire         cmd_ready_out, rsp_valid_out, chip_sel_n_out, out_gate_n_out;
    wire         write_n_out, data_pins_oe_n_out;
    wire [7:0]   rsp_rdata_out, data_pins_out, dev_q;
    wire [14:0]  address_inputs_out;
    int          miscompares = 0, n_tests = 0, n_st, n_rc;
    // shared data lines: host wins while it drives
    wire [7:0]   bus = !data_pins_oe_n_out ? data_pins_out : dev_q;
    always #5 clock_in = ~clock_in;
    nvh_ctrl #(.STORE_CYCLES(50), .RESTORE_CYCLES(40)) uut (.clock_in,
        .rst_in, .cmd_valid_in, .cmd_op_in, .cmd_addr_in, .cmd_wdata_in,
        .cmd_ready_out, .rsp_valid_out, .rsp_rdata_out, .supply_ok_in,
        .chip_sel_n_out, .out_gate_n_out, .write_n_out, .address_inputs_out,
        .data_pins_in(bus), .data_pins_out, .data_pins_oe_n_out);
    nvh_dev dev (.sel_n_in(chip_sel_n_out), .gate_n_in(out_gate_n_out),
        .we_n_in(write_n_out), .addr_in(address_inputs_out), .data_in(bus),
        .supply_in(supply_ok_in), .data_out(dev_q), .n_store_out(n_st),
        .n_recall_out(n_rc));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            miscompares++;
            $display("Error t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    // one command: hold request until ready seen, then await answer
    task automatic cmd(input nvh_op_t op, input logic [14:0] a,
                       input logic [7:0] w);
        int i;
        i = 0;
        @(posedge clock_in);
        #1;
        cmd_valid_in = 1'b1;
        cmd_op_in    = op;
        cmd_addr_in  = a;
        cmd_wdata_in = w;
        do @(negedge clock_in); while (cmd_ready_out !== 1'b1 && ++i < 9000);
        @(posedge clock_in);
        #1 cmd_valid_in = 1'b0;
        do @(negedge clock_in); while (rsp_valid_out !== 1'b1 && ++i < 9000);
        rd = rsp_rdata_out;
        // a command that never finishes counts as a mismatch
        if (i >= 9000) miscompares++;
    endtask
    // writes and reads at the top address, top bit aliasing checked
    task automatic t_rw;
        cmd(NVH_OP_WRITE, 15'h1234, 8'ha5);
        cmd(NVH_OP_WRITE, 15'h7fff, 8'h3c);
        cmd(NVH_OP_WRITE, 15'h3fff, 8'h11);
        cmd(NVH_OP_READ, 15'h1234, 8'h00);
        chk(rd, 8'ha5);
        cmd(NVH_OP_READ, 15'h7fff, 8'h00);
        chk(rd, 8'h3c);
        cmd(NVH_OP_READ, 15'h3fff, 8'h00);
        chk(rd, 8'h11);
    endtask
    // stores with and without writes, then recall restores the copy
    task automatic t_swsr;
        cmd(NVH_OP_STORE, 15'h0000, 8'h00);
        cmd(NVH_OP_STORE, 15'h0000, 8'h00);
        chk(n_st, 2);
        cmd(NVH_OP_WRITE, 15'h1234, 8'h00);
        cmd(NVH_OP_RECALL, 15'h0000, 8'h00);
        chk(n_rc, 1);
        cmd(NVH_OP_READ, 15'h1234, 8'h00);
        chk(rd, 8'ha5);
    endtask
    // supply loss after a write, then a clean loss
    task automatic t_pwr;
        cmd(NVH_OP_WRITE, 15'h0010, 8'h77);
        repeat (2) begin
            @(posedge clock_in);
            #1 supply_ok_in = 1'b0;
            repeat (10) @(posedge clock_in);
            #1;
            chk(cmd_ready_out, 1'b0);
            supply_ok_in = 1'b1;
        end
        chk(n_st, 3);
        cmd(NVH_OP_READ, 15'h0010, 8'h00);
        chk(rd, 8'h77);
    endtask
    task automatic end_of_test;
        $display("tests %0d miscompares %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    initial begin
        repeat (8) @(posedge clock_in);
        #1 rst_in = 1'b0;
        t_rw;
        t_swsr;
        t_pwr;
        end_of_test;
    end
    // watchdog well past the expected run
    initial begin
        #100000;
        miscompares++;
        end_of_test;
    end
endmodule
